// [core/slrp_pkg.sv]
// Shared constants, codes and types for the sleep, wake timer and pin function bank
package slrp_pkg;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [31:0] ADDR_SLEEP_WAKE_CONFIG = 32'h20000380;
   localparam logic [31:0] ADDR_WAKE_INTERVAL = 32'h20000384;
   localparam logic [31:0] ADDR_TEMPERATURE_MONITOR = 32'h2000038C;
   localparam logic [31:0] ADDR_PIN_FUNCTION_SELECT_LOW = 32'h20000394;
   localparam logic [31:0] ADDR_PIN_OUTPUT_LEVEL = 32'h200003F0;
   localparam logic [31:0] ADDR_WAKE_STATUS = 32'h200003F4;
   localparam logic [31:0] ADDR_WAKE_COUNT = 32'h200003F8;

   // ----------------------------------------------------------------
   // Field positions and widths
   // ----------------------------------------------------------------
   localparam int BIT_GLOBAL_ENABLE = 31;
   localparam int BIT_KEEP_MEMORY = 16;
   localparam int BIT_SOURCE_SELECT = 15;
   localparam int BIT_REAPPLY = 13;
   localparam int BIT_REALIGN = 12;
   localparam int BIT_TIMER_ENABLE = 10;
   localparam int TEMP_WIDTH = 12;
   localparam int PIN_COUNT = 4;
   localparam int FUNC_WIDTH = 6;
   localparam int PIN_FIELD_STRIDE = 8;
   localparam int SYNC_STAGES = 2;
   localparam int STATUS_BIT_ASLEEP = 0;
   localparam int STATUS_BIT_ARMED = 1;
   localparam int STATUS_BIT_SOURCE = 2;
   localparam logic [31:0] PIN_SELECT_MASK = 32'h3F3F3F3F;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_SLEEP_WAKE_CONFIG = 32'h00000000;
   localparam logic [31:0] RST_WAKE_INTERVAL = 32'h00000000;
   localparam logic [31:0] RST_PIN_FUNCTION = 32'h00000000;
   localparam logic [PIN_COUNT-1:0] RST_PIN_LEVEL = 4'h0;

   // ----------------------------------------------------------------
   // Pin function codes
   // ----------------------------------------------------------------
   localparam logic [FUNC_WIDTH-1:0] FN_IRQ_IN_A = 6'h04;
   localparam logic [FUNC_WIDTH-1:0] FN_IRQ_IN_B = 6'h05;
   localparam logic [FUNC_WIDTH-1:0] FN_IRQ_OUT_A = 6'h06;
   localparam logic [FUNC_WIDTH-1:0] FN_IRQ_OUT_B = 6'h07;
   localparam logic [FUNC_WIDTH-1:0] FN_SERIAL_TX = 6'h0C;
   localparam logic [FUNC_WIDTH-1:0] FN_SERIAL_RX = 6'h0D;
   localparam logic [FUNC_WIDTH-1:0] FN_SERIAL_CLK = 6'h0E;
   localparam logic [FUNC_WIDTH-1:0] FN_PLAIN_OUT_BASE = 6'h18;
   localparam logic [FUNC_WIDTH-1:0] FN_CLOCK_OUT = 6'h24;

   // Sleep sequencing states
   typedef enum logic [1:0] {SLRP_AWAKE, SLRP_ASLEEP, SLRP_WOKEN} slrp_sleep_t;

   // Selector field of one pin out of the packed register
   function automatic logic [FUNC_WIDTH-1:0] pin_field(input logic [31:0] word, input int n);
      pin_field = word[n*PIN_FIELD_STRIDE +: FUNC_WIDTH];
   endfunction : pin_field

endpackage : slrp_pkg

// [core/slrp_if.sv]
// Configuration carried from the register bank to the pin multiplexer
`timescale 1ns/1ps
interface slrp_if;
   logic [31:0] pin_function;
   logic [slrp_pkg::PIN_COUNT-1:0] pin_level;
   logic global_enable;

   // Register bank drives, multiplexer listens
   modport bank (output pin_function, output pin_level, output global_enable);
   modport mux (input pin_function, input pin_level, input global_enable);
endinterface : slrp_if

// [core/slrp_sync.sv]
// Two flip-flop synchroniser for levels entering from outside the clock domain
`timescale 1ns/1ps
module slrp_sync #(
   parameter int WIDTH = 1,
   parameter int STAGES = slrp_pkg::SYNC_STAGES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] stage [STAGES];

   // Shift chain; only the last stage leaves the module
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         for (int i = 0; i < STAGES; i++) begin
            stage[i] <= '0;
         end
      end else begin
         stage[0] <= d;
         for (int i = 1; i < STAGES; i++) begin
            stage[i] <= stage[i-1];
         end
      end
   end

   assign q = stage[STAGES-1];
endmodule : slrp_sync

// [core/slrp_pin_mux.sv]
// Per-pin function routing for the four general-purpose pins
`timescale 1ns/1ps
module slrp_pin_mux (
   input wire logic clock,
   input wire logic rst_n,
   slrp_if.mux cfg,
   input wire logic [slrp_pkg::PIN_COUNT-1:0] pin_in_sync,
   input wire logic interrupt_output_a,
   input wire logic interrupt_output_b,
   input wire logic serial_port_tx_line,
   input wire logic programmable_clock_out,
   output logic [slrp_pkg::PIN_COUNT-1:0] pin_out,
   output logic [slrp_pkg::PIN_COUNT-1:0] pin_oe,
   output logic interrupt_input_a,
   output logic interrupt_input_b,
   output logic serial_port_rx_line,
   output logic serial_port_bit_clock
);
   logic [slrp_pkg::PIN_COUNT-1:0] next_out;
   logic [slrp_pkg::PIN_COUNT-1:0] next_oe;
   logic [3:0] next_in;
   logic [slrp_pkg::FUNC_WIDTH-1:0] code;

   // Decode every selector; inputs from several pins are OR-ed together
   always_comb begin
      next_out = '0;
      next_oe = '0;
      next_in = '0;
      code = '0;
      for (int n = 0; n < slrp_pkg::PIN_COUNT; n++) begin
         code = slrp_pkg::pin_field(cfg.pin_function, n);
         if (cfg.global_enable) begin
            if (code == slrp_pkg::FN_IRQ_IN_A) next_in[0] = next_in[0] | pin_in_sync[n];
            if (code == slrp_pkg::FN_IRQ_IN_B) next_in[1] = next_in[1] | pin_in_sync[n];
            if (code == slrp_pkg::FN_SERIAL_RX) next_in[2] = next_in[2] | pin_in_sync[n];
            if (code == slrp_pkg::FN_SERIAL_CLK) next_in[3] = next_in[3] | pin_in_sync[n];
            if (code == slrp_pkg::FN_IRQ_OUT_A) begin
               next_oe[n] = 1'b1;
               next_out[n] = interrupt_output_a;
            end
            if (code == slrp_pkg::FN_IRQ_OUT_B) begin
               next_oe[n] = 1'b1;
               next_out[n] = interrupt_output_b;
            end
            if (code == slrp_pkg::FN_SERIAL_TX) begin
               next_oe[n] = 1'b1;
               next_out[n] = serial_port_tx_line;
            end
            if (code == slrp_pkg::FN_PLAIN_OUT_BASE + 6'(n)) begin
               next_oe[n] = 1'b1;
               next_out[n] = cfg.pin_level[n];
            end
            if (code == slrp_pkg::FN_CLOCK_OUT) begin
               next_oe[n] = 1'b1;
               next_out[n] = programmable_clock_out;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pin_out <= '0;
         pin_oe <= '0;
         {serial_port_bit_clock, serial_port_rx_line} <= 2'h0;
         {interrupt_input_b, interrupt_input_a} <= 2'h0;
      end else begin
         pin_out <= next_out;
         pin_oe <= next_oe;
         {serial_port_bit_clock, serial_port_rx_line} <= next_in[3:2];
         {interrupt_input_b, interrupt_input_a} <= next_in[1:0];
      end
   end
endmodule : slrp_pin_mux

// [core/slrp_regs.sv]
// Sleep, wake timer, temperature and pin function register bank with its control logic
`timescale 1ns/1ps

// Notes on behaviour
// - Top config bit gates timer, retention, pins
// - Retain bit keeps backed memory in sleep
// - Source bit picks RC or crystal slow clock
// - Reapply bit loads timer on configure, self-clears
// - Realign bit restarts timer phase at sleep
// - Realign bit clears after armed sleep entry
// - Enable bit arms alarm that wakes device
// - Interval is full 32-bit tick count
// - Temperature in low twelve bits, signed
// - Codes 4 and 5 feed interrupt inputs
// - Codes 6 and 7 drive interrupt outputs
// - Codes C and D are serial lines
// - Code E carries shared serial bit clock
// - Code 18 plus pin index makes plain output
// - Code 24 drives programmable clock out
module slrp_regs (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [31:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   output logic [31:0] bus_rdata,
   input wire logic configure_device_command,
   input wire logic sleep_state,
   input wire logic [slrp_pkg::TEMP_WIDTH-1:0] temperature_sample,
   input wire logic slow_rc_oscillator,
   input wire logic slow_crystal_oscillator,
   input wire logic [slrp_pkg::PIN_COUNT-1:0] pin_in,
   output logic [slrp_pkg::PIN_COUNT-1:0] pin_out,
   output logic [slrp_pkg::PIN_COUNT-1:0] pin_oe,
   input wire logic interrupt_output_a,
   input wire logic interrupt_output_b,
   input wire logic serial_port_tx_line,
   input wire logic programmable_clock_out,
   output logic interrupt_input_a,
   output logic interrupt_input_b,
   output logic serial_port_rx_line,
   output logic serial_port_bit_clock,
   output logic wake_request,
   output logic keep_memory_in_sleep,
   output logic wake_timer_source_select
);

   // ----------------------------------------------------------------
   // Storage and internal state
   // ----------------------------------------------------------------
   logic [31:0] sleep_wake_config;
   logic [31:0] wake_interval;
   logic [31:0] pin_function_select_low;
   logic [slrp_pkg::PIN_COUNT-1:0] pin_output_level;
   logic [slrp_pkg::TEMP_WIDTH-1:0] temperature_monitor;

   // Timer settings in force, loaded only by a configure command
   logic active_source;
   logic active_enable;
   logic [31:0] active_interval;

   logic [31:0] tick_count;
   logic slow_prev;
   slrp_pkg::slrp_sleep_t sleep_fsm;
   slrp_pkg::slrp_sleep_t next_sleep_fsm;

   logic [1:0] slow_sync;
   logic [slrp_pkg::PIN_COUNT-1:0] pin_in_sync;
   logic slow_now;
   logic tick;
   logic alarm;
   logic armed;
   logic sleep_entry;
   logic reapply_now;
   logic cfg_write;
   logic [31:0] next_rdata;

   slrp_if pin_cfg ();

   // ----------------------------------------------------------------
   // Crossing of slow clocks and pins
   // ----------------------------------------------------------------

   // Slow oscillators are sampled as levels; edges become ticks here
   slrp_sync #(
      .WIDTH(2),
      .STAGES(slrp_pkg::SYNC_STAGES)
   ) u_slow_sync (
      .clock(clock),
      .rst_n(rst_n),
      .d({slow_crystal_oscillator, slow_rc_oscillator}),
      .q(slow_sync)
   );

   // Pin levels pass the same two stages before routing
   slrp_sync #(
      .WIDTH(slrp_pkg::PIN_COUNT),
      .STAGES(slrp_pkg::SYNC_STAGES)
   ) u_pin_sync (
      .clock(clock),
      .rst_n(rst_n),
      .d(pin_in),
      .q(pin_in_sync)
   );

   // ----------------------------------------------------------------
   // Decoded strobes and timer terms
   // ----------------------------------------------------------------

   assign armed = sleep_wake_config[slrp_pkg::BIT_GLOBAL_ENABLE] & active_enable;
   // slow clock chosen by active source
   assign slow_now = active_source ? slow_sync[1] : slow_sync[0];
   assign tick = slow_now & ~slow_prev;
   assign alarm = armed & tick & (tick_count + 32'h00000001 >= active_interval);
   assign sleep_entry = (sleep_fsm == slrp_pkg::SLRP_AWAKE) & sleep_state;
   assign cfg_write = bus_write & (bus_addr == slrp_pkg::ADDR_SLEEP_WAKE_CONFIG);
   // reapply acts only on the command
   assign reapply_now = configure_device_command
      & sleep_wake_config[slrp_pkg::BIT_REAPPLY];

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------

   // Sleep config; a software write beats the self-clearing of bits 13 and 12
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sleep_wake_config <= slrp_pkg::RST_SLEEP_WAKE_CONFIG;
      end else if (cfg_write) begin
         sleep_wake_config <= bus_wdata;
      end else begin
         if (reapply_now) begin
            sleep_wake_config[slrp_pkg::BIT_REAPPLY] <= 1'b0;
         end
         if (sleep_entry & armed) begin
            sleep_wake_config[slrp_pkg::BIT_REALIGN] <= 1'b0;
         end
      end
   end

   // Wake interval is plain storage until a configure command takes it
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wake_interval <= slrp_pkg::RST_WAKE_INTERVAL;
      end else if (bus_write & (bus_addr == slrp_pkg::ADDR_WAKE_INTERVAL)) begin
         wake_interval <= bus_wdata;
      end
   end

   // Pin selectors; gap bits are never stored
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pin_function_select_low <= slrp_pkg::RST_PIN_FUNCTION;
      end else if (bus_write & (bus_addr == slrp_pkg::ADDR_PIN_FUNCTION_SELECT_LOW)) begin
         pin_function_select_low <= bus_wdata & slrp_pkg::PIN_SELECT_MASK;
      end
   end

   // Levels for pins in their plain output mode
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pin_output_level <= slrp_pkg::RST_PIN_LEVEL;
      end else if (bus_write & (bus_addr == slrp_pkg::ADDR_PIN_OUTPUT_LEVEL)) begin
         pin_output_level <= bus_wdata[slrp_pkg::PIN_COUNT-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         temperature_monitor <= '0;
      end else begin
         temperature_monitor <= temperature_sample;
      end
   end

   // ----------------------------------------------------------------
   // Wake timer
   // ----------------------------------------------------------------

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         active_source <= 1'b0;
         active_enable <= 1'b0;
         active_interval <= slrp_pkg::RST_WAKE_INTERVAL;
      end else if (reapply_now) begin
         active_source <= sleep_wake_config[slrp_pkg::BIT_SOURCE_SELECT];
         active_enable <= sleep_wake_config[slrp_pkg::BIT_TIMER_ENABLE];
         active_interval <= wake_interval;
      end
   end

   // Tick counter runs freely while armed, so the phase drifts unless realigned
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tick_count <= '0;
         slow_prev <= 1'b0;
      end else if (sleep_entry & sleep_wake_config[slrp_pkg::BIT_REALIGN]) begin
         tick_count <= '0;
         slow_prev <= slow_now;
      end else begin
         slow_prev <= slow_now;
         if (!armed | alarm) begin
            tick_count <= '0;
         end else if (tick) begin
            tick_count <= tick_count + 32'h00000001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Sleep sequencing
   // ----------------------------------------------------------------

   // Woken state waits for the power sequencer to drop sleep
   always_comb begin
      next_sleep_fsm = sleep_fsm;
      unique case (sleep_fsm)
         slrp_pkg::SLRP_AWAKE: begin
            if (sleep_state) next_sleep_fsm = slrp_pkg::SLRP_ASLEEP;
         end
         slrp_pkg::SLRP_ASLEEP: begin
            if (!sleep_state) begin
               next_sleep_fsm = slrp_pkg::SLRP_AWAKE;
            end else if (alarm) begin
               next_sleep_fsm = slrp_pkg::SLRP_WOKEN;
            end
         end
         slrp_pkg::SLRP_WOKEN: begin
            if (!sleep_state) next_sleep_fsm = slrp_pkg::SLRP_AWAKE;
         end
         default: next_sleep_fsm = slrp_pkg::SLRP_AWAKE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sleep_fsm <= slrp_pkg::SLRP_AWAKE;
      end else begin
         sleep_fsm <= next_sleep_fsm;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wake_request <= 1'b0;
      end else begin
         wake_request <= (sleep_fsm == slrp_pkg::SLRP_ASLEEP) & sleep_state & alarm;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         keep_memory_in_sleep <= 1'b0;
      end else begin
         keep_memory_in_sleep <= sleep_wake_config[slrp_pkg::BIT_GLOBAL_ENABLE]
            & sleep_wake_config[slrp_pkg::BIT_KEEP_MEMORY];
      end
   end

   // Source actually in use, for the oscillator power control
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wake_timer_source_select <= 1'b0;
      end else begin
         wake_timer_source_select <= active_source;
      end
   end

   // ----------------------------------------------------------------
   // Pin routing
   // ----------------------------------------------------------------

   assign pin_cfg.global_enable = sleep_wake_config[slrp_pkg::BIT_GLOBAL_ENABLE];
   assign pin_cfg.pin_function = pin_function_select_low;
   assign pin_cfg.pin_level = pin_output_level;

   slrp_pin_mux u_pin_mux (
      .clock(clock),
      .rst_n(rst_n),
      .cfg(pin_cfg.mux),
      .pin_in_sync(pin_in_sync),
      .interrupt_output_a(interrupt_output_a),
      .interrupt_output_b(interrupt_output_b),
      .serial_port_tx_line(serial_port_tx_line),
      .programmable_clock_out(programmable_clock_out),
      .pin_out(pin_out),
      .pin_oe(pin_oe),
      .interrupt_input_a(interrupt_input_a),
      .interrupt_input_b(interrupt_input_b),
      .serial_port_rx_line(serial_port_rx_line),
      .serial_port_bit_clock(serial_port_bit_clock)
   );

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------

   // Read mux; unmapped addresses answer zero
   always_comb begin
      next_rdata = '0;
      unique case (bus_addr)
         slrp_pkg::ADDR_SLEEP_WAKE_CONFIG: next_rdata = sleep_wake_config;
         slrp_pkg::ADDR_WAKE_INTERVAL: next_rdata = wake_interval;
         slrp_pkg::ADDR_TEMPERATURE_MONITOR: begin
            next_rdata[slrp_pkg::TEMP_WIDTH-1:0] = temperature_monitor;
         end
         slrp_pkg::ADDR_PIN_FUNCTION_SELECT_LOW: next_rdata = pin_function_select_low;
         slrp_pkg::ADDR_PIN_OUTPUT_LEVEL: begin
            next_rdata[slrp_pkg::PIN_COUNT-1:0] = pin_output_level;
         end
         slrp_pkg::ADDR_WAKE_STATUS: begin
            next_rdata[slrp_pkg::STATUS_BIT_ASLEEP] = (sleep_fsm != slrp_pkg::SLRP_AWAKE);
            next_rdata[slrp_pkg::STATUS_BIT_ARMED] = armed;
            next_rdata[slrp_pkg::STATUS_BIT_SOURCE] = active_source;
         end
         slrp_pkg::ADDR_WAKE_COUNT: next_rdata = tick_count;
         default: next_rdata = '0;
      endcase
   end

   // Data stands only in the cycle after the read strobe
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bus_rdata <= '0;
      end else if (bus_read) begin
         bus_rdata <= next_rdata;
      end else begin
         bus_rdata <= '0;
      end
   end

endmodule : slrp_regs

// [sim/slrp_props.sv]
// Port-level assertions for the sleep, wake timer and pin function bank
`timescale 1ns/1ps
module slrp_props (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [31:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   input wire logic [31:0] bus_rdata,
   input wire logic configure_device_command,
   input wire logic [slrp_pkg::PIN_COUNT-1:0] pin_oe,
   input wire logic wake_request,
   input wire logic keep_memory_in_sleep,
   input wire logic wake_timer_source_select
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Config write, the start of most multi-step checks
   sequence cfg_wr;
      bus_write && bus_addr == slrp_pkg::ADDR_SLEEP_WAKE_CONFIG;
   endsequence
   a_read_idle: assert property (!bus_read |=> bus_rdata == 32'h0)
      else $error("read data not idle");
   a_unmapped_zero: assert property (bus_read && bus_addr[31:8] != 24'h200003 |=>
      bus_rdata == 32'h0) else $error("unmapped read not zero");
   a_temp_upper: assert property (bus_read && bus_addr == 32'h2000038C |=>
      bus_rdata[31:12] == 20'h0) else $error("temperature upper bits set");
   a_pin_reserved: assert property (bus_read && bus_addr == 32'h20000394 |=>
      (bus_rdata & ~slrp_pkg::PIN_SELECT_MASK) == 32'h0) else $error("pin reserved bits set");
   a_keep_memory: assert property (cfg_wr |-> ##2 keep_memory_in_sleep ==
      ($past(bus_wdata[31], 2) & $past(bus_wdata[16], 2))) else $error("retention wrong");
   a_wake_pulse: assert property (wake_request |=> !wake_request)
      else $error("wake request too long");
   a_source_hold: assert property (!$past(configure_device_command, 2) |->
      $stable(wake_timer_source_select)) else $error("source moved without command");
   a_input_codes: assert property (bus_write && bus_addr == 32'h20000394 &&
      bus_wdata[5:0] inside {6'h04, 6'h05, 6'h0D, 6'h0E} |-> ##2 !pin_oe[0])
      else $error("input pin driven");
   a_global_off: assert property ((cfg_wr and !bus_wdata[31]) |-> ##2 pin_oe == 4'h0)
      else $error("pins driven while disabled");
endmodule : slrp_props
bind slrp_regs slrp_props slrp_props_inst (.clock, .rst_n, .bus_addr, .bus_wdata, .bus_write,
   .bus_read, .bus_rdata, .configure_device_command, .pin_oe, .wake_request,
   .keep_memory_in_sleep, .wake_timer_source_select);

// [sim/tb_top.sv]
// Self-checking bench for the sleep, wake timer and pin function bank
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
   localparam logic [31:0] CFG = slrp_pkg::ADDR_SLEEP_WAKE_CONFIG;
   localparam logic [31:0] PIN = slrp_pkg::ADDR_PIN_FUNCTION_SELECT_LOW;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] bus_addr = 32'h0;
   logic [31:0] bus_wdata = 32'h0;
   logic bus_write = 1'b0;
   logic bus_read = 1'b0;
   logic configure_device_command = 1'b0;
   logic sleep_state = 1'b0;
   logic slow_rc_oscillator = 1'b0;
   logic slow_crystal_oscillator = 1'b0;
   logic interrupt_output_a = 1'b0;
   logic interrupt_output_b = 1'b0;
   logic serial_port_tx_line = 1'b0;
   logic programmable_clock_out = 1'b0;
   logic [11:0] temperature_sample = 12'h0;
   logic [3:0] pin_in = 4'h0;
   logic [31:0] bus_rdata, rd, d;
   logic [3:0] pin_out, pin_oe;
   logic interrupt_input_a, interrupt_input_b, serial_port_rx_line, serial_port_bit_clock;
   logic wake_request, keep_memory_in_sleep, wake_timer_source_select;
   logic [5:0] v, got;
   logic [5:0] codes [13] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h0C, 6'h0D, 6'h0E, 6'h18, 6'h19,
      6'h1A, 6'h1B, 6'h24, 6'h3F};
   logic [31:0] addrs [9] = '{CFG, 32'h20000384, 32'h2000038C, PIN, 32'h200003F0,
      32'h200003F4, 32'h200003F8, 32'h20000388, 32'h20000480};
   int miscompares = 0;
   int samples_checked = 0;
   int wakes = 0;
   slrp_regs slrp_regs_inst (.clock, .rst_n, .bus_addr, .bus_wdata, .bus_write, .bus_read,
      .bus_rdata, .configure_device_command, .sleep_state, .temperature_sample,
      .slow_rc_oscillator, .slow_crystal_oscillator, .pin_in, .pin_out, .pin_oe,
      .interrupt_output_a, .interrupt_output_b, .serial_port_tx_line, .programmable_clock_out,
      .interrupt_input_a, .interrupt_input_b, .serial_port_rx_line, .serial_port_bit_clock,
      .wake_request, .keep_memory_in_sleep, .wake_timer_source_select);
   // 50 ns clock
   always #25 clock = ~clock;
   // Wake pulses seen so far
   always @(posedge clock) if (wake_request === 1'b1) wakes <= wakes + 1;
   task automatic wr(input logic [31:0] a, input logic [31:0] dat);
      @(posedge clock);
      bus_write <= 1'b1;
      bus_addr <= a;
      bus_wdata <= dat;
      @(posedge clock);
      bus_write <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [31:0] a);
      @(posedge clock);
      bus_read <= 1'b1;
      bus_addr <= a;
      @(posedge clock);
      bus_read <= 1'b0;
      @(negedge clock);
      rd = bus_rdata;
   endtask : rd_reg
   task automatic pulse_cmd();
      @(posedge clock);
      configure_device_command <= 1'b1;
      @(posedge clock);
      configure_device_command <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : pulse_cmd
   // One slow RC tick; the crystal toggles in step with it, so a wrong source counts the same
   task automatic tick();
      @(posedge clock);
      slow_rc_oscillator <= 1'b1;
      slow_crystal_oscillator <= ~slow_crystal_oscillator;
      repeat (6) @(posedge clock);
      slow_rc_oscillator <= 1'b0;
      slow_crystal_oscillator <= ~slow_crystal_oscillator;
      repeat (6) @(posedge clock);
      @(negedge clock);
   endtask : tick
   // v: level, pin in, clock out, tx, irq b, irq a
   function automatic logic [5:0] exp_pin(input logic [5:0] c, input int n, input logic [5:0] v);
      logic oe;
      logic o;
      oe = c inside {6'h06, 6'h07, 6'h0C, 6'h24} || c == 6'(6'h18 + n);
      o = c == 6'h06 ? v[0] : c == 6'h07 ? v[1] : c == 6'h0C ? v[2] : c == 6'h24 ? v[3] : v[5];
      return {oe, oe & o, v[4] & c == 6'h04, v[4] & c == 6'h05, v[4] & c == 6'h0D,
         v[4] & c == 6'h0E};
   endfunction : exp_pin
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   initial begin
      void'($urandom(32'hC1FFC166));
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      foreach (addrs[i]) begin
         rd_reg(addrs[i]);
         `CHK(rd, 32'h0)
      end
      // Random storage, interval and read-only temperature
      repeat (6) begin
         d = $urandom;
         @(posedge clock);
         temperature_sample <= d[27:16];
         wr(CFG, d);
         rd_reg(CFG);
         `CHK(rd, d)
         wr(32'h20000384, ~d);
         rd_reg(32'h20000384);
         `CHK(rd, ~d)
         wr(32'h2000038C, d);
         rd_reg(32'h2000038C);
         `CHK(rd, {20'h0, d[27:16]})
      end
      wr(CFG, 32'h80010000);
      for (int i = 0; i < 13; i++) begin
         for (int n = 0; n < 4; n++) begin
            v = 6'($urandom);
            @(posedge clock);
            {programmable_clock_out, serial_port_tx_line, interrupt_output_b,
               interrupt_output_a} <= v[3:0];
            pin_in <= {4{v[4]}};
            wr(32'h200003F0, {28'h0, {4{v[5]}}});
            d = 32'(codes[i]) << (8 * n);
            wr(PIN, d | 32'hC0C0C0C0);
            rd_reg(PIN);
            `CHK(rd, d)
            repeat (4) @(negedge clock);
            got = {pin_oe[n], pin_oe[n] & pin_out[n], interrupt_input_a, interrupt_input_b,
               serial_port_rx_line, serial_port_bit_clock};
            `CHK(got, exp_pin(codes[i], n, v))
            `CHK(pin_oe & ~(4'h1 << n), 4'h0)
         end
      end
      `CHK(keep_memory_in_sleep, 1'b1)
      // Drive pin 0 first, so switching the bank off has something to undo
      wr(PIN, 32'h00000006);
      rd_reg(PIN);
      `CHK({rd[5:0], pin_oe}, {6'h06, 4'h1})
      wr(CFG, 32'h00002000);
      pulse_cmd();
      `CHK(pin_oe, 4'h0)
      wr(CFG, 32'h80008000);
      pulse_cmd();
      `CHK(wake_timer_source_select, 1'b0)
      wr(CFG, 32'h8000A000);
      pulse_cmd();
      `CHK(wake_timer_source_select, 1'b1)
      wr(32'h20000384, 32'h00000003);
      wr(CFG, 32'h80003400);
      pulse_cmd();
      rd_reg(CFG);
      `CHK({rd, wake_timer_source_select}, {32'h80001400, 1'b0})
      @(posedge clock);
      sleep_state <= 1'b1;
      rd_reg(CFG);
      `CHK(rd, 32'h80000400)
      for (int t = 1; t <= 3; t++) begin
         tick();
         `CHK(wakes, int'(t == 3))
      end
      // Woken, still armed, RC source in force
      rd_reg(32'h200003F4);
      `CHK(rd, 32'h00000003)
      conclude();
   end
endmodule : tb_top
